//--- pkg/phy_status_pkg.sv
// Constants for the detailed status / 10BASE-T operations register slice.
// Assumes a management frame layout of preamble, start, op, address, TA.
package phy_status_pkg;

    // Register addresses on the management bus
    localparam logic [4:0] REG_DETAIL_STATUS = 5'h11;
    localparam logic [4:0] REG_TENBT_OPS = 5'h12;
    localparam logic [4:0] VENDOR_FIRST = 5'h19;
    localparam logic [4:0] VENDOR_LAST = 5'h1f;

    // Detailed status bit positions
    localparam int B17_AN_PROG0 = 11;
    localparam int B17_SIG_LOST = 10;
    localparam int B17_PLL_ERR = 9;
    localparam int B17_FALSE_CAR = 8;
    localparam int B17_INV_SYM = 7;
    localparam int B17_HALT_SYM = 6;
    localparam int B17_PREM_END = 5;
    localparam int B17_JABBER = 2;
    localparam int B17_REM_FAULT = 1;
    localparam int B17_LINK = 0;

    // 10BASE-T operations bit positions
    localparam int B18_REM_JAB = 15;
    localparam int B18_POL_REV = 14;
    localparam int B18_BUS_MODE = 12;
    localparam int B18_XOVER = 11;
    localparam int B18_RX_FLOAT = 10;
    localparam int B18_VENDOR = 9;
    localparam int B18_TEST_SEL = 8;
    localparam int B18_JAB_INH = 5;

    // Values after reset
    localparam logic TEST_SEL_RST = 1'b0;
    localparam logic JAB_INH_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [2:0] AN_PROG_RST = 3'h0;

    // Data bus mode codes
    localparam logic [1:0] BUS_MODE_MII = 2'h0;
    localparam logic [1:0] BUS_MODE_SERIAL = 2'h1;

    // Management frame counts
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] TA_LAST = 5'h01;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // Latched-high flag slots; 0..7 clear on status read, 8..9 on ops read
    localparam int NUM_LH = 10;
    localparam int NUM_LH17 = 8;

    typedef enum logic [3:0] {
        ST_PRE = 4'h1,
        ST_HDR = 4'h2,
        ST_TA = 4'h4,
        ST_DAT = 4'h8
    } mgmt_state_t;

endpackage : phy_status_pkg

//--- logic/latched_flag.sv
// One latched status flag, high-latching or low-latching.
// Assumes rd_clr is a one-cycle pulse when the owning register is read.
`timescale 1ns/1ps
module latched_flag
    import phy_status_pkg::*;
#(
    parameter bit ACTIVE_LOW = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Condition and read strobe
    input wire logic cond,
    input wire logic rd_clr,
    // Flag
    output logic flag
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        if (ACTIVE_LOW) begin
            // Low stays low until read, then follows the condition
            flag_d = cond & (flag_q | rd_clr);
        end else begin
            // Set wins over the read clear
            flag_d = cond | (flag_q & ~rd_clr);
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            flag_q <= FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

    property p_flag_hold;
        @(posedge clock) disable iff (!nrst)
        (flag_q != ACTIVE_LOW) && !rd_clr && (cond == ACTIVE_LOW)
            |=> (flag_q == $past(flag_q));
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("latched flag changed without a read");

endmodule : latched_flag

//--- logic/phy_status_regs.sv
// Detailed status and 10BASE-T operations registers behind a serial
// management slave. Assumes straps are stable while nrst is low and the
// management clock is slow enough for three-stage pin sampling.
`timescale 1ns/1ps
// Summary of operation
// - Status bit 11 shows bit 0 of the highest progress code seen.
// - Seven receive-error and jabber flags latch high; jabber inhibit gates jabber.
// - Remote fault latches high; link valid latches low; both reset zero.
// - Remote jabber and reversed polarity latch high in the ops register.
// - Two-bit bus mode is read-only, taken from straps at reset.
// - Receive float bit tri-states receive outputs; defaults come from straps.
// - Vendor registers 25 to 31 reachable only while the control bit is zero.
// - Read-write test path select, reset zero, chooses between two test paths.
module phy_status_regs
    import phy_status_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // Straps
    input wire logic [4:0] phy_addr_strap,
    input wire logic [1:0] bus_mode_strap,
    input wire logic xover_strap,
    input wire logic rx_float_strap,
    input wire logic vendor_strap,
    // Datapath events
    input wire logic sig_lost_ev,
    input wire logic pll_err_ev,
    input wire logic false_car_ev,
    input wire logic inv_sym_ev,
    input wire logic halt_sym_ev,
    input wire logic prem_end_ev,
    input wire logic jabber_ev,
    input wire logic rem_fault_ev,
    input wire logic link_ok,
    input wire logic rem_jabber_ev,
    input wire logic pol_rev_ev,
    input wire logic [2:0] an_progress,
    // Receive interface
    input wire logic [3:0] rxd_in,
    input wire logic rx_dv_in,
    input wire logic rx_er_in,
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic rx_er,
    output logic rx_oe_n,
    // Control and test
    input wire logic test_path_one,
    input wire logic test_path_two,
    output logic test_path_select,
    output logic test_out,
    output logic auto_crossover_enable,
    output logic [1:0] bus_mode,
    output logic vendor_access_en,
    output logic vendor_hit
);

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q, mdc_lvl_q, mdc_lvl_d;
    logic dio_s1_q, dio_s2_q, dio_s3_q, dio_lvl_q, dio_lvl_d;
    logic rise, fall;

    always_comb begin
        mdc_lvl_d = (mdc_s2_q == mdc_s3_q) ? mdc_s3_q : mdc_lvl_q;
        dio_lvl_d = (dio_s2_q == dio_s3_q) ? dio_s3_q : dio_lvl_q;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            {mdc_s1_q, mdc_s2_q, mdc_s3_q, mdc_lvl_q} <= 4'h0;
            {dio_s1_q, dio_s2_q, dio_s3_q, dio_lvl_q} <= 4'h0;
        end else begin
            {mdc_s1_q, mdc_s2_q, mdc_s3_q} <= {mdc, mdc_s1_q, mdc_s2_q};
            {dio_s1_q, dio_s2_q, dio_s3_q} <= {mdio_in, dio_s1_q, dio_s2_q};
            mdc_lvl_q <= mdc_lvl_d;
            dio_lvl_q <= dio_lvl_d;
        end
    end

    assign rise = mdc_lvl_d & ~mdc_lvl_q;
    assign fall = ~mdc_lvl_d & mdc_lvl_q;

    ////////////////////////////////////////////////////////////////////////
    // Register contents
    logic [NUM_LH-1:0] lh_cond, lh_clr, lh_q;
    logic link_q;
    logic [2:0] an_max_q, an_max_d;
    logic [1:0] bus_mode_q;
    logic xover_q, float_q, vendor_q, tsel_q, jinh_q;
    logic xover_d, float_d, vendor_d, tsel_d, jinh_d;
    logic rd17_q, rd18_q, wr18_q;
    logic [15:0] r17, r18, shr_q;

    assign lh_cond = {pol_rev_ev, rem_jabber_ev, rem_fault_ev,
                      jabber_ev & ~jinh_q, prem_end_ev, halt_sym_ev,
                      inv_sym_ev, false_car_ev, pll_err_ev, sig_lost_ev};
    assign lh_clr = {{(NUM_LH - NUM_LH17){rd18_q}}, {NUM_LH17{rd17_q}}};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LH; gi++) begin : g_lh
            latched_flag #(.ACTIVE_LOW(1'b0)) u_flag (
                .clock(clock),
                .nrst(nrst),
                .cond(lh_cond[gi]),
                .rd_clr(lh_clr[gi]),
                .flag(lh_q[gi])
            );
        end
    endgenerate

    latched_flag #(.ACTIVE_LOW(1'b1)) u_link (
        .clock(clock),
        .nrst(nrst),
        .cond(link_ok),
        .rd_clr(rd17_q),
        .flag(link_q)
    );

    always_comb begin
        // Highest progress kept; a read restarts from the live code
        an_max_d = rd17_q ? an_progress : an_max_q;
        if (an_progress > an_max_d) begin
            an_max_d = an_progress;
        end
        xover_d = xover_q;
        float_d = float_q;
        vendor_d = vendor_q;
        tsel_d = tsel_q;
        jinh_d = jinh_q;
        if (wr18_q) begin
            xover_d = shr_q[B18_XOVER];
            float_d = shr_q[B18_RX_FLOAT];
            vendor_d = shr_q[B18_VENDOR];
            tsel_d = shr_q[B18_TEST_SEL];
            jinh_d = shr_q[B18_JAB_INH];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            an_max_q <= AN_PROG_RST;
            bus_mode_q <= bus_mode_strap;
            xover_q <= xover_strap;
            float_q <= rx_float_strap;
            vendor_q <= vendor_strap;
            tsel_q <= TEST_SEL_RST;
            jinh_q <= JAB_INH_RST;
        end else begin
            an_max_q <= an_max_d;
            xover_q <= xover_d;
            float_q <= float_d;
            vendor_q <= vendor_d;
            tsel_q <= tsel_d;
            jinh_q <= jinh_d;
        end
    end

    always_comb begin
        r17 = 16'h0000;
        r17[B17_AN_PROG0] = an_max_q[0];
        r17[B17_SIG_LOST] = lh_q[0];
        r17[B17_PLL_ERR] = lh_q[1];
        r17[B17_FALSE_CAR] = lh_q[2];
        r17[B17_INV_SYM] = lh_q[3];
        r17[B17_HALT_SYM] = lh_q[4];
        r17[B17_PREM_END] = lh_q[5];
        r17[B17_JABBER] = lh_q[6];
        r17[B17_REM_FAULT] = lh_q[7];
        r17[B17_LINK] = link_q;
        r18 = 16'h0000;
        r18[B18_REM_JAB] = lh_q[8];
        r18[B18_POL_REV] = lh_q[9];
        r18[B18_BUS_MODE +: 2] = bus_mode_q;
        r18[B18_XOVER] = xover_q;
        r18[B18_RX_FLOAT] = float_q;
        r18[B18_VENDOR] = vendor_q;
        r18[B18_TEST_SEL] = tsel_q;
        r18[B18_JAB_INH] = jinh_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Management frame engine
    mgmt_state_t st_q, st_d;
    logic [5:0] pre_q, pre_d;
    logic [4:0] cnt_q, cnt_d;
    logic [11:0] hdr_q, hdr_d;
    logic [15:0] shr_d;
    logic rdop_q, rdop_d, out_q, out_d, oen_q, oen_d;
    logic rd17_d, rd18_d, wr18_d, vhit_q, vhit_d;

    always_comb begin
        logic [12:0] hdr_n;
        hdr_n = {hdr_q, dio_lvl_d};
        st_d = st_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        shr_d = shr_q;
        rdop_d = rdop_q;
        out_d = out_q;
        oen_d = oen_q;
        rd17_d = 1'b0;
        rd18_d = 1'b0;
        wr18_d = 1'b0;
        vhit_d = 1'b0;
        // Snapshot in the clearing cycle so no event slips past a read
        if (rd17_q) begin
            shr_d = r17;
        end else if (rd18_q) begin
            shr_d = r18;
        end
        case (st_q)
            ST_PRE: begin
                if (rise && dio_lvl_d && pre_q != PREAMBLE_LEN) begin
                    pre_d = pre_q + 6'h01;
                end else if (rise && !dio_lvl_d) begin
                    pre_d = 6'h00;
                    cnt_d = 5'h00;
                    if (pre_q == PREAMBLE_LEN) begin
                        st_d = ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (rise) begin
                    hdr_d = hdr_n[11:0];
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == HDR_LAST) begin
                        cnt_d = 5'h00;
                        rdop_d = (hdr_n[11:10] == OP_READ);
                        st_d = ST_PRE;
                        if (hdr_n[12] && hdr_n[9:5] == phy_addr_strap) begin
                            if (hdr_n[4:0] >= VENDOR_FIRST
                                    && hdr_n[4:0] <= VENDOR_LAST) begin
                                vhit_d = ~vendor_q;
                            end else if (hdr_n[11:10] == OP_WRITE) begin
                                st_d = (hdr_n[4:0] == REG_TENBT_OPS) ?
                                    ST_TA : ST_PRE;
                            end else if (hdr_n[11:10] == OP_READ) begin
                                // Read strobe; snapshot and clear follow it
                                rd17_d = (hdr_n[4:0] == REG_DETAIL_STATUS);
                                rd18_d = (hdr_n[4:0] == REG_TENBT_OPS);
                                st_d = (rd17_d | rd18_d) ? ST_TA : ST_PRE;
                            end
                        end
                    end
                end
            end
            ST_TA: begin
                if ((rdop_q && fall) || (!rdop_q && rise)) begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == TA_LAST) begin
                        cnt_d = 5'h00;
                        st_d = ST_DAT;
                        out_d = 1'b0;
                        oen_d = ~rdop_q;
                    end
                end
            end
            ST_DAT: begin
                if (rdop_q && fall) begin
                    if (cnt_q == DATA_BITS) begin
                        oen_d = 1'b1;
                        st_d = ST_PRE;
                    end else begin
                        out_d = shr_q[15];
                        shr_d = {shr_q[14:0], 1'b0};
                        cnt_d = cnt_q + 5'h01;
                    end
                end else if (!rdop_q && rise) begin
                    shr_d = {shr_q[14:0], dio_lvl_d};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == DATA_BITS - 5'h01) begin
                        wr18_d = 1'b1;
                        st_d = ST_PRE;
                    end
                end
            end
            default: begin
                st_d = ST_PRE;
                oen_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q <= ST_PRE;
            pre_q <= 6'h00;
            cnt_q <= 5'h00;
            hdr_q <= 12'h000;
            shr_q <= 16'h0000;
            {rdop_q, out_q, rd17_q, rd18_q, wr18_q, vhit_q} <= 6'h00;
            oen_q <= 1'b1;
        end else begin
            st_q <= st_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            shr_q <= shr_d;
            {rdop_q, out_q, oen_q} <= {rdop_d, out_d, oen_d};
            {rd17_q, rd18_q, wr18_q, vhit_q} <= {rd17_d, rd18_d, wr18_d, vhit_d};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic [3:0] rxd_q;
    logic rx_dv_q, rx_er_q, rx_oe_n_q, tout_q, ven_en_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            {rxd_q, rx_dv_q, rx_er_q} <= 6'h00;
            {rx_oe_n_q, tout_q, ven_en_q} <= 3'h0;
        end else begin
            {rxd_q, rx_dv_q, rx_er_q} <= {rxd_in, rx_dv_in, rx_er_in};
            rx_oe_n_q <= float_q;
            tout_q <= tsel_q ? test_path_one : test_path_two;
            ven_en_q <= ~vendor_q;
        end
    end

    assign {mdio_out, mdio_oe_n} = {out_q, oen_q};
    assign {rxd, rx_dv, rx_er, rx_oe_n} = {rxd_q, rx_dv_q, rx_er_q, rx_oe_n_q};
    assign {test_path_select, test_out} = {tsel_q, tout_q};
    assign {auto_crossover_enable, bus_mode} = {xover_q, bus_mode_q};
    assign {vendor_access_en, vendor_hit} = {ven_en_q, vhit_q};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_quiet_prog;
        !rd17_q ##1 !rd17_q;
    endsequence
    property p_an_prog;
        @(posedge clock) disable iff (!nrst)
        s_quiet_prog |-> an_max_q >= $past(an_max_q);
    endproperty
    a_an_prog: assert property (p_an_prog)
        else $error("progress maximum decreased without a read");

    property p_jab_set;
        @(posedge clock) disable iff (!nrst)
        jabber_ev && !jinh_q |=> lh_q[6];
    endproperty
    a_jab_set: assert property (p_jab_set)
        else $error("jabber flag not set");

    property p_jab_inh;
        @(posedge clock) disable iff (!nrst)
        jinh_q && !lh_q[6] |=> !lh_q[6];
    endproperty
    a_jab_inh: assert property (p_jab_inh)
        else $error("jabber flag set while inhibited");

    property p_link_low;
        @(posedge clock) disable iff (!nrst)
        !link_ok ##1 !rd17_q |=> !link_q;
    endproperty
    a_link_low: assert property (p_link_low)
        else $error("link bit set after failure without read");

    property p_rjab;
        @(posedge clock) disable iff (!nrst)
        rem_jabber_ev |=> lh_q[8] && r18[B18_REM_JAB];
    endproperty
    a_rjab: assert property (p_rjab)
        else $error("remote jabber flag not set");

    property p_bus_mode;
        @(posedge clock) disable iff (!nrst)
        1'b1 |=> $stable(bus_mode_q);
    endproperty
    a_bus_mode: assert property (p_bus_mode)
        else $error("bus mode changed outside reset");

    property p_rx_float;
        @(posedge clock) disable iff (!nrst)
        wr18_q ##1 1'b1 |=> rx_oe_n_q == $past(shr_q[B18_RX_FLOAT], 2);
    endproperty
    a_rx_float: assert property (p_rx_float)
        else $error("receive float not applied after write");

    property p_vendor;
        @(posedge clock) disable iff (!nrst)
        vendor_q ##1 vendor_q |-> !vendor_access_en && !vhit_q;
    endproperty
    a_vendor: assert property (p_vendor)
        else $error("vendor access while blocked");

    property p_test_sel;
        @(posedge clock) disable iff (!nrst)
        tsel_q && $stable(tsel_q) |=> test_out == $past(test_path_one);
    endproperty
    a_test_sel: assert property (p_test_sel)
        else $error("test path one not selected");

    sequence s_turn;
        st_q == ST_TA && rdop_q && fall && cnt_q == TA_LAST;
    endsequence
    property p_turn;
        @(posedge clock) disable iff (!nrst)
        s_turn |=> !mdio_oe_n && !mdio_out;
    endproperty
    a_turn: assert property (p_turn)
        else $error("turnaround zero not driven");

endmodule : phy_status_regs

//--- bench/sta_model.sv
// Station management controller for the serial management bus.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module sta_model
    import phy_status_pkg::*;
#(
    parameter int HALF = 8
) (
    // Clock
    input wire logic clock,
    // Management pins
    input wire logic mdio_line,
    output logic mdc,
    output logic sta_bit,
    output logic sta_oe_n
);

    initial begin
        mdc = 1'b0;
        sta_bit = 1'b1;
        sta_oe_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One bit period: set data after the fall, sample at the rise
    task automatic cyc(input logic d, input logic drv, output logic s);
        @(negedge clock);
        mdc = 1'b0;
        sta_bit = d;
        sta_oe_n = ~drv;
        repeat (HALF) @(negedge clock);
        mdc = 1'b1;
        s = mdio_line;
        repeat (HALF - 1) @(negedge clock);
    endtask : cyc

    ////////////////////////////////////////////////////////////////////////
    // Whole frame with fresh preamble; clock stands low afterwards
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ta);
        logic s;
        logic [13:0] hdr;
        hdr = {2'b01, op, pa, ra};
        rd = 16'h0000;
        ta = 1'b0;
        for (int i = 0; i < 32; i++) cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) cyc(hdr[i], 1'b1, s);
        if (op == OP_WRITE) begin
            cyc(1'b1, 1'b1, s);
            cyc(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--) cyc(wd[i], 1'b1, s);
        end else begin
            cyc(1'b0, 1'b0, s);
            cyc(1'b0, 1'b0, ta);
            for (int i = 15; i >= 0; i--) begin
                cyc(1'b0, 1'b0, s);
                rd[i] = s;
            end
        end
        @(negedge clock);
        mdc = 1'b0;
        sta_oe_n = 1'b1;
        repeat (HALF) @(negedge clock);
    endtask : xfer

endmodule : sta_model

//--- bench/tb_phy_detail_status_10bt_ops_regs.sv
// Self-checking bench for the status and operations register slice.
// Assumes the management controller model and a pulled-up data line.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_phy_detail_status_10bt_ops_regs;
    import phy_status_pkg::*;
    localparam int LIMIT = 60000;
    localparam logic [4:0] PA = 5'h0b;
    logic clock, nrst, mdc, mdio_out, mdio_oe_n, sta_bit, sta_oe_n, mdio_line;
    logic [1:0] bus_mode_strap, bus_mode;
    logic xover_strap, rx_float_strap, vendor_strap, link_ok;
    logic [9:0] ev;
    logic [2:0] an_progress;
    logic [3:0] rxd_in, rxd;
    logic rx_dv_in, rx_er_in, rx_dv, rx_er, rx_oe_n, vendor_hit;
    logic test_path_one, test_path_two, test_path_select, test_out;
    logic auto_crossover_enable, vendor_access_en;
    logic [31:0] seed, r;
    logic [15:0] m17, m18, d;
    logic ta;
    int an_max, mismatches, tests_run, cycles, h;
    int hits = 0;
    bit link_low;
    int pos[10] = '{B17_SIG_LOST, B17_PLL_ERR, B17_FALSE_CAR, B17_INV_SYM,
        B17_HALT_SYM, B17_PREM_END, B17_JABBER, B17_REM_FAULT, B18_REM_JAB,
        B18_POL_REV};

    assign mdio_line = !mdio_oe_n ? mdio_out : (!sta_oe_n ? sta_bit : 1'b1);

    phy_status_regs u_dut (.clock(clock), .nrst(nrst), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .phy_addr_strap(PA), .bus_mode_strap(bus_mode_strap),
        .xover_strap(xover_strap), .rx_float_strap(rx_float_strap),
        .vendor_strap(vendor_strap), .sig_lost_ev(ev[0]), .pll_err_ev(ev[1]),
        .false_car_ev(ev[2]), .inv_sym_ev(ev[3]), .halt_sym_ev(ev[4]),
        .prem_end_ev(ev[5]), .jabber_ev(ev[6]), .rem_fault_ev(ev[7]),
        .link_ok(link_ok), .rem_jabber_ev(ev[8]), .pol_rev_ev(ev[9]),
        .an_progress(an_progress), .rxd_in(rxd_in), .rx_dv_in(rx_dv_in),
        .rx_er_in(rx_er_in), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
        .rx_oe_n(rx_oe_n), .test_path_one(test_path_one),
        .test_path_two(test_path_two), .test_path_select(test_path_select),
        .test_out(test_out), .auto_crossover_enable(auto_crossover_enable),
        .bus_mode(bus_mode), .vendor_access_en(vendor_access_en),
        .vendor_hit(vendor_hit));

    sta_model #(.HALF(8)) u_sta (.clock(clock), .mdio_line(mdio_line),
        .mdc(mdc), .sta_bit(sta_bit), .sta_oe_n(sta_oe_n));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        if (vendor_hit === 1'b1) hits++;
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    ////////////////////////////////////////////////////////////////////////
    // Model-checked register read; read side effects applied to the model
    task automatic rd_reg(input logic [4:0] ra);
        logic [15:0] e;
        e = m18;
        if (ra == REG_DETAIL_STATUS) begin
            e = m17;
            e[B17_AN_PROG0] = an_max[0];
            e[B17_LINK] = link_ok & ~link_low;
        end
        u_sta.xfer(OP_READ, PA, ra, 16'h0000, d, ta);
        `CHK(ta, 1'b0)
        `CHK(d, e)
        if (ra == REG_DETAIL_STATUS) begin
            m17 = '0;
            an_max = an_progress;
            link_low = ~link_ok;
        end else begin
            m18[15:14] = 2'b00;
        end
    endtask : rd_reg

    // Frame the device must leave unanswered
    task automatic rd_none(input logic [4:0] pa, input logic [4:0] ra);
        u_sta.xfer(OP_READ, pa, ra, 16'h0000, d, ta);
        `CHK({ta, d}, 17'h1ffff)
    endtask : rd_none

    task automatic wr12(input logic [15:0] w);
        u_sta.xfer(OP_WRITE, PA, REG_TENBT_OPS, w, d, ta);
        m18 = (m18 & ~16'h0f20) | (w & 16'h0f20);
        repeat (4) @(negedge clock);
        `CHK(auto_crossover_enable, m18[B18_XOVER])
        `CHK(rx_oe_n, m18[B18_RX_FLOAT])
        `CHK(vendor_access_en, ~m18[B18_VENDOR])
        `CHK(test_path_select, m18[B18_TEST_SEL])
        `CHK(bus_mode, m18[13:12])
    endtask : wr12

    task automatic pulse(input logic [9:0] m);
        @(negedge clock);
        ev = m;
        @(negedge clock);
        ev = '0;
        for (int i = 0; i < 10; i++) begin
            if (m[i] && i >= 8) m18[pos[i]] = 1'b1;
            else if (m[i] && !(i == 6 && m18[B18_JAB_INH])) m17[pos[i]] = 1'b1;
        end
    endtask : pulse

    task automatic set_an(input logic [2:0] v);
        @(negedge clock);
        an_progress = v;
        if (v > an_max) an_max = v;
    endtask : set_an

    task automatic done(input string n);
        $display("Test %s done", n);
    endtask : done

    task automatic finish_test();
        $display("Counts: %0d compared, %0d mismatched", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h3d0352c3;
        r = rnd();
        {bus_mode_strap, xover_strap, rx_float_strap, vendor_strap} = r[4:0];
        nrst = 1'b0;
        ev = '0;
        link_ok = 1'b1;
        an_progress = 3'h0;
        {rxd_in, rx_dv_in, rx_er_in, test_path_one, test_path_two} = '0;
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        m17 = '0;
        m18 = {2'b00, r[4:0], 9'h000};
        an_max = 0;
        link_low = 1'b1;
        `CHK(rx_oe_n, rx_float_strap)
        `CHK(vendor_access_en, ~vendor_strap)
        `CHK({bus_mode, auto_crossover_enable}, r[4:2])
        rd_reg(REG_DETAIL_STATUS);
        rd_reg(REG_DETAIL_STATUS);
        rd_reg(REG_TENBT_OPS);
        done("reset");
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            pulse(r[9:0]);
            rd_reg(REG_DETAIL_STATUS);
            rd_reg(REG_TENBT_OPS);
            rd_reg(REG_DETAIL_STATUS);
        end
        wr12(16'h0020);
        pulse(10'h040);
        rd_reg(REG_DETAIL_STATUS);
        done("flags");
        set_an(3'h5);
        set_an(3'h2);
        rd_reg(REG_DETAIL_STATUS);
        rd_reg(REG_DETAIL_STATUS);
        set_an(3'h3);
        set_an(3'h0);
        rd_reg(REG_DETAIL_STATUS);
        @(negedge clock) link_ok = 1'b0;
        @(negedge clock) link_ok = 1'b1;
        link_low = 1'b1;
        rd_reg(REG_DETAIL_STATUS);
        rd_reg(REG_DETAIL_STATUS);
        done("progress_link");
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wr12(r[15:0]);
            {test_path_one, test_path_two} = r[17:16];
            {rxd_in, rx_dv_in, rx_er_in} = r[23:18];
            repeat (2) @(negedge clock);
            `CHK(test_out, m18[B18_TEST_SEL] ? r[17] : r[16])
            `CHK({rxd, rx_dv, rx_er}, r[23:18])
            rd_reg(REG_TENBT_OPS);
        end
        u_sta.xfer(OP_WRITE, PA, REG_DETAIL_STATUS, 16'hffff, d, ta);
        rd_reg(REG_DETAIL_STATUS);
        done("writes");
        wr12(16'h0000);
        h = hits;
        rd_none(PA, VENDOR_FIRST);
        rd_none(PA, VENDOR_LAST);
        rd_none(PA, 5'h18);
        `CHK(hits - h, 2)
        wr12(16'h0200);
        rd_none(PA, VENDOR_FIRST);
        rd_none(PA ^ 5'h01, REG_DETAIL_STATUS);
        `CHK(hits - h, 2)
        done("vendor");
        finish_test();
    end

endmodule : tb_phy_detail_status_10bt_ops_regs
